// >>> include/srx_pkg.sv
/*
 * Shared constants for the remote reset and forced-stop input block.
 * Assumes a single 250 MHz clock and a remote input word laid out by station occupancy.
 */
package srx_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned HOLD_MS = 50;
    localparam int unsigned HOLD_CYCLES = HOLD_MS * 1000 * CLK_MHZ;
    localparam int unsigned HOLD_CNT_W = 24;
    localparam int unsigned REM_W = 64;
    localparam int unsigned BIT_ALM_CLR_ONE = 26;
    localparam int unsigned BIT_ALM_CLR_TWO = 58;
    localparam int unsigned BIT_SPEC_SEL = 42;
    localparam int unsigned BIT_ABS_INCR = 43;
    localparam int unsigned PARAM_W = 16;
    localparam int unsigned D1_DIGIT_LSB = 4;
    localparam int unsigned DIGIT_W = 4;
    localparam logic [3:0] D1_RESET_SHUTOFF = 4'h1;
    localparam int unsigned SYNC_STAGES = 3;
    localparam int unsigned STAT_W = 6;
    localparam int unsigned ST_ALARM = 0;
    localparam int unsigned ST_FSTOP = 1;
    localparam int unsigned ST_BASE_EN = 2;
    localparam int unsigned ST_DYN_BRAKE = 3;
    localparam int unsigned ST_INCR = 4;
    localparam int unsigned ST_REG_MODE = 5;
    typedef enum logic [0:0] {
        SRX_RUN = 1'b0,
        SRX_FSTOP = 1'b1
    } srx_stop_state_t;
endpackage

// >>> include/srx_if.sv
/*
 * Carrier between the top module and its reset hold timer.
 * Assumes both ends share clk_in.
 */
`timescale 1ns/1ns
interface srx_hold_if;
    logic hold_req;
    logic holding;
    logic clear_pulse;
    modport ctrl (output hold_req, input holding, input clear_pulse);
    modport timer (input hold_req, output holding, output clear_pulse);
endinterface // srx_hold_if

// >>> verilog/srx_hold_timer.sv
/*
 * Hold timer for the alarm-clear input: one pulse per continuous assertion.
 * Assumes hold_req is already synchronous to clk_in.
 */
`timescale 1ns/1ns
module srx_hold_timer #(
    parameter int unsigned HOLD_CYCLES = srx_pkg::HOLD_CYCLES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    srx_hold_if.timer hold
);
    import srx_pkg::*;

    localparam logic [HOLD_CNT_W-1:0] LAST = HOLD_CNT_W'(HOLD_CYCLES - 1);

    logic [HOLD_CNT_W-1:0] count_reg;
    logic done_reg;
    logic pulse_reg;

    // Counting stops at the threshold so a long hold cannot fire twice.
    always_ff @(posedge clk_in) begin
        if (srst_in || !hold.hold_req) begin
            count_reg <= '0; // [R13]
            done_reg <= 1'b0;
        end else if (!done_reg) begin
            if (count_reg == LAST) begin
                done_reg <= 1'b1; // [R3]
            end else begin
                count_reg <= count_reg + HOLD_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            pulse_reg <= 1'b0;
        end else begin
            pulse_reg <= hold.hold_req && !done_reg && (count_reg == LAST); // [R13]
        end
    end

    assign hold.clear_pulse = pulse_reg;
    assign hold.holding = hold.hold_req;
endmodule // srx_hold_timer

// >>> verilog/srx_top.sv
/*
 * Remote position-mode select, alarm-clear input with hold time, and
 * connector-only forced stop for a servo amplifier network interface.
 * Assumes the remote word is synchronous to clk_in and the forced-stop pin is not.
 */
// Functional notes
// R1: The absolute/incremental bit counts only in register specifying mode with the absolute command system configured.
// R2: When that bit counts, low means absolute position data and high means incremental.
// R3: The alarm-clear bit sits at one position for one station and another for two, and must be held 50 ms.
// R4: Alarm classes marked non-clearable stay latched whatever the alarm-clear input does.
// R5: By default the alarm-clear input with no alarm leaves the base drive on.
// R6: With the reset-shutoff digit set, the alarm-clear input with no alarm turns the base drive off.
// R7: The master must not use alarm-clear as a stop or assert it while the motor runs.
// R8: Forced stop comes only from the connector pin, never from a remote bit.
// R9: Forced stop going inactive enters the stop state: base drive off and dynamic brake on.
// R10: The stop state is left when the forced-stop input returns active.
// R11: Every status signal is given both as a remote output bit and as a connector output.
// R12: The specifying-system bit picks point tables when low and register instruction codes when high.
// R13: The hold counter restarts whenever the input drops, and the clear fires once per hold.
`timescale 1ns/1ns
module srx_top #(
    parameter int unsigned HOLD_CYCLES = srx_pkg::HOLD_CYCLES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [srx_pkg::REM_W-1:0] remote_word_in,
    input wire logic two_station_in,
    input wire logic forced_stop_input_in,
    input wire logic abs_command_system_in,
    input wire logic [srx_pkg::PARAM_W-1:0] function_select_d1_param_in,
    input wire logic alarm_set_in,
    input wire logic alarm_clearable_in,
    output logic alarm_out,
    output logic alarm_clear_pulse_out,
    output logic base_drive_en_out,
    output logic dyn_brake_out,
    output logic forced_stop_state_out,
    output logic abs_incr_valid_out,
    output logic pos_incremental_out,
    output logic spec_register_mode_out,
    output logic [srx_pkg::STAT_W-1:0] status_remote_out,
    output logic [srx_pkg::STAT_W-1:0] status_ext_out
);
    import srx_pkg::*;

    srx_hold_if hold_bus ();

    logic [SYNC_STAGES-1:0] fstop_sync_reg;
    logic fstop_level_reg;
    srx_stop_state_t stop_state_reg;
    srx_stop_state_t stop_state_next;
    logic alarm_reg;
    logic alarm_fixed_reg;
    logic reset_req;
    logic shutoff_on_reset;
    logic base_en_reg;
    logic brake_reg;
    logic abs_valid_reg;
    logic incr_reg;
    logic reg_mode_reg;
    logic [STAT_W-1:0] status_reg;

    // The alarm-clear bit is taken from the position that the occupancy selects.
    assign reset_req = two_station_in ? remote_word_in[BIT_ALM_CLR_TWO]
                                      : remote_word_in[BIT_ALM_CLR_ONE]; // [R3]
    assign hold_bus.hold_req = reset_req;

    // The timer owns the hold count; this module only picks the bit to be timed.
    srx_hold_timer #(
        .HOLD_CYCLES(HOLD_CYCLES)
    ) u_hold (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .hold(hold_bus)
    );

    // The pin is asynchronous; three stages, and a change counts once stages two and three agree.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fstop_sync_reg <= '0;
        end else begin
            fstop_sync_reg <= {fstop_sync_reg[SYNC_STAGES-2:0], forced_stop_input_in}; // [R8]
        end
    end

    // The level resets low so the amplifier starts stopped until the pin is seen active.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            fstop_level_reg <= 1'b0;
        end else if (fstop_sync_reg[1] == fstop_sync_reg[2]) begin
            fstop_level_reg <= fstop_sync_reg[2]; // [R8]
        end
    end

    // The stop state follows the filtered pin level only, so no remote bit can reach it.
    always_comb begin
        stop_state_next = stop_state_reg;
        unique case (stop_state_reg)
            SRX_RUN: begin
                if (!fstop_level_reg) begin
                    stop_state_next = SRX_FSTOP; // [R9]
                end
            end
            SRX_FSTOP: begin
                if (fstop_level_reg) begin
                    stop_state_next = SRX_RUN; // [R10]
                end
            end
        endcase
    end

    // Reset lands in the stop state so the power stage stays off until the pin is proven active.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            stop_state_reg <= SRX_FSTOP;
        end else begin
            stop_state_reg <= stop_state_next;
        end
    end

    // A new alarm in the clear cycle wins, so no alarm is lost.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            alarm_reg <= 1'b0;
        end else if (alarm_set_in) begin
            alarm_reg <= 1'b1;
        end else if (hold_bus.clear_pulse && !alarm_fixed_reg) begin
            alarm_reg <= 1'b0; // [R3] [R4]
        end
    end

    // Only a reset removes a latched class; the clear input has no path to it.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            alarm_fixed_reg <= 1'b0;
        end else if (alarm_set_in && !alarm_clearable_in) begin
            alarm_fixed_reg <= 1'b1; // [R4]
        end
    end

    assign shutoff_on_reset = function_select_d1_param_in[D1_DIGIT_LSB +: DIGIT_W]
                              == D1_RESET_SHUTOFF;

    // The brake follows the next state so it engages on the same edge as the state change.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            brake_reg <= 1'b1;
        end else begin
            brake_reg <= (stop_state_next == SRX_FSTOP); // [R9]
        end
    end

    // Shutoff under reset applies only while the input is held and no alarm is present.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            base_en_reg <= 1'b0;
        end else if (stop_state_next == SRX_FSTOP || alarm_reg) begin
            base_en_reg <= 1'b0; // [R9]
        end else if (hold_bus.holding && shutoff_on_reset) begin
            base_en_reg <= 1'b0; // [R6]
        end else begin
            base_en_reg <= 1'b1; // [R5] [R10]
        end
    end

    // Mode bits come straight from the remote word, which already runs on this clock.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reg_mode_reg <= 1'b0;
        end else begin
            reg_mode_reg <= remote_word_in[BIT_SPEC_SEL]; // [R12]
        end
    end

    // The select bit is ignored outside register mode with the absolute system configured.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            abs_valid_reg <= 1'b0;
        end else begin
            abs_valid_reg <= remote_word_in[BIT_SPEC_SEL] && abs_command_system_in; // [R1]
        end
    end

    // Incremental is reported only where the bit counts, so a stale bit never leaks through.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            incr_reg <= 1'b0;
        end else begin
            incr_reg <= remote_word_in[BIT_SPEC_SEL] && abs_command_system_in
                        && remote_word_in[BIT_ABS_INCR]; // [R1] [R2]
        end
    end

    // One register feeds both the network bits and the connector pins so they never disagree.
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            status_reg <= '0;
        end else begin
            status_reg[ST_ALARM] <= alarm_reg;
            status_reg[ST_FSTOP] <= (stop_state_reg == SRX_FSTOP);
            status_reg[ST_BASE_EN] <= base_en_reg;
            status_reg[ST_DYN_BRAKE] <= brake_reg;
            status_reg[ST_INCR] <= incr_reg;
            status_reg[ST_REG_MODE] <= reg_mode_reg;
        end
    end

    // The single outputs lead the status word by one cycle.
    assign status_remote_out = status_reg; // [R11]
    assign status_ext_out = status_reg; // [R11]
    assign alarm_out = alarm_reg;
    assign alarm_clear_pulse_out = hold_bus.clear_pulse;
    assign base_drive_en_out = base_en_reg;
    assign dyn_brake_out = brake_reg;
    assign forced_stop_state_out = (stop_state_reg == SRX_FSTOP);
    assign abs_incr_valid_out = abs_valid_reg;
    assign pos_incremental_out = incr_reg;
    assign spec_register_mode_out = reg_mode_reg;
endmodule // srx_top

// >>> verif/srx_top_chk.sv
/* Checker for srx_top port timing.
   Assumes one clock and synchronous active-high reset. */
`timescale 1ns/1ns
module srx_top_chk import srx_pkg::*; #(
    parameter int unsigned HOLD_CYCLES = srx_pkg::HOLD_CYCLES
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic [REM_W-1:0] remote_word_in,
    input wire logic two_station_in,
    input wire logic forced_stop_input_in,
    input wire logic abs_command_system_in,
    input wire logic alarm_out,
    input wire logic alarm_clear_pulse_out,
    input wire logic base_drive_en_out,
    input wire logic dyn_brake_out,
    input wire logic forced_stop_state_out,
    input wire logic abs_incr_valid_out,
    input wire logic pos_incremental_out,
    input wire logic spec_register_mode_out,
    input wire logic [STAT_W-1:0] status_remote_out,
    input wire logic [STAT_W-1:0] status_ext_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    logic rb;
    int unsigned run_reg;
    assign rb = two_station_in ? remote_word_in[BIT_ALM_CLR_TWO] : remote_word_in[BIT_ALM_CLR_ONE];
    always_ff @(posedge clk_in) begin
        run_reg <= (srst_in || !rb) ? 0 : run_reg + 1;
    end
    property p_hold; alarm_clear_pulse_out |-> run_reg == HOLD_CYCLES; endproperty
    a_hold: assert property (p_hold) else $error("clear pulse off hold count");
    property p_once; alarm_clear_pulse_out |=> !alarm_clear_pulse_out; endproperty
    a_once: assert property (p_once) else $error("clear pulse too long");
    property p_clr; $fell(alarm_out) |-> $past(alarm_clear_pulse_out); endproperty
    a_clr: assert property (p_clr) else $error("alarm fell without pulse");
    property p_brk; dyn_brake_out |-> !base_drive_en_out; endproperty
    a_brk: assert property (p_brk) else $error("base on with brake");
    property p_enter; !forced_stop_input_in [*6] |=> dyn_brake_out; endproperty
    a_enter: assert property (p_enter) else $error("stop not entered");
    property p_leave; forced_stop_input_in [*8] |=> !forced_stop_state_out; endproperty
    a_leave: assert property (p_leave) else $error("stop not left");
    property p_valid; !$past(srst_in) |-> abs_incr_valid_out ==
        $past(remote_word_in[BIT_SPEC_SEL] & abs_command_system_in); endproperty
    a_valid: assert property (p_valid) else $error("valid wrong");
    property p_incr; !$past(srst_in) |-> pos_incremental_out == $past(remote_word_in[BIT_SPEC_SEL]
        & abs_command_system_in & remote_word_in[BIT_ABS_INCR]); endproperty
    a_incr: assert property (p_incr) else $error("incremental wrong");
    property p_spec; !$past(srst_in) |-> spec_register_mode_out ==
        $past(remote_word_in[BIT_SPEC_SEL]); endproperty
    a_spec: assert property (p_spec) else $error("mode wrong");
    property p_stat; !$past(srst_in) |-> status_ext_out == status_remote_out &&
        status_remote_out == $past({spec_register_mode_out, pos_incremental_out, dyn_brake_out,
        base_drive_en_out, forced_stop_state_out, alarm_out}); endproperty
    a_stat: assert property (p_stat) else $error("status wrong");
endmodule // srx_top_chk
bind srx_top srx_top_chk #(.HOLD_CYCLES(HOLD_CYCLES)) srx_top_chk_i (.*);

// >>> verif/srx_master_model.sv
/* Master station model building the remote input word.
   Assumes the bench drives its inputs just after the clock edge. */
`timescale 1ns/1ns
module srx_master_model (
    input wire logic two_station_in,
    input wire logic clr_in,
    input wire logic wrong_pos_in,
    input wire logic spec_in,
    input wire logic incr_in,
    input wire logic noise_in,
    output logic [srx_pkg::REM_W-1:0] remote_word_out
);
    import srx_pkg::*;
    logic alt;
    assign alt = two_station_in ^ wrong_pos_in;
    always_comb begin
        remote_word_out = noise_in ? ~((64'h1 << BIT_ALM_CLR_ONE) | (64'h1 << BIT_ALM_CLR_TWO)) : '0;
        remote_word_out[BIT_SPEC_SEL] = spec_in | noise_in;
        remote_word_out[BIT_ABS_INCR] = incr_in | noise_in;
        remote_word_out[alt ? BIT_ALM_CLR_TWO : BIT_ALM_CLR_ONE] = clr_in;
    end
endmodule // srx_master_model

// >>> verif/srx_top_bench.sv
/* Self-checking bench for srx_top.
   Assumes the master model and checker are compiled alongside. */
`timescale 1ns/1ns
module srx_top_bench;
    import srx_pkg::*;
    localparam int unsigned HC = 20;
    logic clk_in = 0, srst_in = 1, two_st = 0, pin = 1, abs_sys = 0, a_set = 0, a_clr = 1;
    logic clr = 0, wrong = 0, spec = 0, incr = 0, noise = 0;
    logic [PARAM_W-1:0] fsel = 16'h0000;
    logic [REM_W-1:0] rw;
    logic alm, pls, base, brk, fst, vld, inc, regm;
    logic [STAT_W-1:0] st_r, st_e;
    int n_mismatch = 0, comparisons = 0, cyc = 0, n_pls = 0;
    srx_master_model srx_master_model_i (.two_station_in(two_st), .clr_in(clr),
        .wrong_pos_in(wrong), .spec_in(spec), .incr_in(incr), .noise_in(noise),
        .remote_word_out(rw));
    srx_top #(.HOLD_CYCLES(HC)) srx_top_i (.clk_in(clk_in), .srst_in(srst_in),
        .remote_word_in(rw), .two_station_in(two_st), .forced_stop_input_in(pin),
        .abs_command_system_in(abs_sys), .function_select_d1_param_in(fsel),
        .alarm_set_in(a_set), .alarm_clearable_in(a_clr), .alarm_out(alm),
        .alarm_clear_pulse_out(pls), .base_drive_en_out(base), .dyn_brake_out(brk),
        .forced_stop_state_out(fst), .abs_incr_valid_out(vld), .pos_incremental_out(inc),
        .spec_register_mode_out(regm), .status_remote_out(st_r), .status_ext_out(st_e));
    always #2 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (pls === 1'b1) n_pls <= n_pls + 1;
        if (cyc == 2000) begin
            n_mismatch++;
            test_done();
        end
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Clear requests are only made with the motor idle, never as a stop.
    task automatic hold(input int n);
        clr = 1;
        step(n);
        clr = 0;
        step(3);
    endtask
    task automatic raise(input logic c);
        a_clr = c;
        a_set = 1;
        step(1);
        a_set = 0;
        step(1);
    endtask
    initial begin
        step(5);
        srst_in = 0;
        chk({brk, fst, base, alm}, 4'hc);
        step(8);
        chk({brk, fst, base, alm}, 4'h2);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            {spec, abs_sys, incr} = i[2:0];
            step(2);
            chk({regm, vld, inc}, {i[2], i[2] & i[1], i[2] & i[1] & i[0]});
            chk(st_r, st_e);
        end
        {spec, abs_sys, incr} = 3'h0;
        $display("test modes done");
        raise(1);
        chk(alm, 1);
        hold(HC - 1);
        chk(alm, 1);
        hold(HC + 8);
        chk({alm, n_pls[3:0]}, 5'h01);
        two_st = 1;
        wrong = 1;
        raise(1);
        hold(HC + 8);
        chk(alm, 1);
        wrong = 0;
        hold(HC + 8);
        chk({alm, n_pls[3:0]}, 5'h02);
        $display("test alarm clear done");
        clr = 1;
        step(3);
        chk(base, 1);
        fsel = 16'h0010;
        step(2);
        chk(base, 0);
        clr = 0;
        step(2);
        chk(base, 1);
        fsel = 16'h0000;
        $display("test shutoff done");
        noise = 1;
        step(4);
        chk({brk, fst, base}, 3'h1);
        pin = 0;
        step(8);
        chk({brk, fst, base}, 3'h6);
        pin = 1;
        step(8);
        chk({brk, fst, base}, 3'h1);
        noise = 0;
        $display("test forced stop done");
        raise(0);
        hold(HC + 8);
        chk({alm, n_pls[3:0]}, 5'h13);
        srst_in = 1;
        step(2);
        srst_in = 0;
        chk(alm, 0);
        $display("test latch done");
        test_done();
    end
endmodule // srx_top_bench
